// [rtl/qmc_nco_pkg.sv]
// package: register map, field layout, reset values and carriers for the phase shadow bank
package qmc_nco_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int SAMPLE_W = 16;
   localparam int PHASE_W = 12;
   localparam int GAIN_W = 11;
   localparam int FREQ_W = 32;
   localparam int SHIFT_W = 16;
   localparam int MIXERS = 2;
   localparam int MIX_AB = 0;
   localparam int MIX_CD = 1;

   localparam logic [ADDR_W-1:0] GAIN_C_OFFSET = 8'h0E;
   localparam logic [ADDR_W-1:0] GAIN_D_OFFSET = 8'h0F;
   localparam logic [ADDR_W-1:0] CD_PHASE_OFFSET = 8'h11;
   localparam logic [ADDR_W-1:0] AB_SHIFT_OFFSET = 8'h12;
   localparam logic [ADDR_W-1:0] CD_SHIFT_OFFSET = 8'h13;
   localparam logic [ADDR_W-1:0] AB_FREQ_LO_OFFSET = 8'h14;
   localparam logic [ADDR_W-1:0] AB_FREQ_HI_OFFSET = 8'h15;
   localparam logic [ADDR_W-1:0] CD_FREQ_LO_OFFSET = 8'h16;
   localparam logic [ADDR_W-1:0] CD_FREQ_HI_OFFSET = 8'h17;
   localparam logic [ADDR_W-1:0] SYNC_CTRL_OFFSET = 8'h1E;
   localparam logic [ADDR_W-1:0] SYNC_STAT_OFFSET = 8'h1F;

   // field positions
   localparam int DELAY_AB_LSB = 14;
   localparam int DELAY_CD_LSB = 12;
   localparam int QMC_SYNC_BIT = 0;
   localparam int MIX_SYNC_BIT = 1;
   localparam int PEND_QMC_BIT = 0;
   localparam int PEND_AB_BIT = 1;
   localparam int PEND_CD_BIT = 2;
   // binary point positions of the gain and phase words
   localparam int GAIN_FRAC = 10;
   localparam int PHASE_FRAC = 12;

   localparam logic [GAIN_W-1:0] GAIN_RESET = 11'h400;
   localparam logic [PHASE_W-1:0] PHASE_RESET = 12'h000;
   localparam logic [SHIFT_W-1:0] SHIFT_RESET = 16'h0000;
   localparam logic [FREQ_W-1:0] FREQ_RESET = 32'h0000_0000;
   localparam logic [1:0] SYNC_CTRL_RESET = 2'h3;

   typedef struct packed {
      logic [1:0] delayAB;
      logic [1:0] delayCD;
      logic [GAIN_W-1:0] gainC;
      logic [GAIN_W-1:0] gainD;
      logic [PHASE_W-1:0] cd_pair_phase_correction;
   } qmc_t;

   typedef struct packed {
      logic [FREQ_W-1:0] frequencyWord;
      logic [SHIFT_W-1:0] phaseShift;
   } mixer_t;

   localparam qmc_t QMC_RESET = '{2'h0, 2'h0, GAIN_RESET, GAIN_RESET, PHASE_RESET};
   localparam mixer_t MIXER_RESET = '{FREQ_RESET, SHIFT_RESET};
endpackage

// [rtl/qmc_nco_phase_shadow_load.sv]
// staged/active CD quadrature correction and AB/CD fine mixer phase settings with auto-sync
// How it works
// - CD phase correction is 12-bit two's complement, weight one part in 4096.
// - correction times D sample is added into the C sample.
// - CD phase write with QMC auto-sync loads both gains and phase together.
// - CD gain and delay writes only stage; active correction waits for sync.
// - AB phase shift adds to upper 16 AB accumulator bits for lookup.
// - CD phase shift adds to upper 16 CD accumulator bits for lookup.
// - AB shift write with mixer auto-sync loads shift and AB frequency word.
// - AB frequency word writes only stage until the AB shift sync.
// - CD shift write with mixer auto-sync loads shift and CD frequency word.
// - CD frequency word writes only stage until the CD shift sync.
// - phase correction and both phase shifts reset to zero.
// - frequency word is 32-bit two's complement, one step is Fs over 2^32.
`timescale 1ns/1ps
`default_nettype none
module qmc_nco_phase_shadow_load
   import qmc_nco_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic syncIn,
   input wire logic signed [SAMPLE_W-1:0] sampleC,
   input wire logic signed [SAMPLE_W-1:0] sampleD,
   output logic signed [SAMPLE_W-1:0] correctedC,
   output logic signed [SAMPLE_W-1:0] correctedD,
   output logic [SHIFT_W-1:0] abLookupAddr,
   output logic [SHIFT_W-1:0] cdLookupAddr,
   output qmc_t qmcActive,
   output mixer_t [MIXERS-1:0] mixActive
);

   ////////////////////////////////////////////////////////////////////////////////
   // reset release
   logic rstMeta;
   logic rstN;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic signed [SAMPLE_W-1:0] sat16(input logic signed [SAMPLE_W+2:0] v);
      logic signed [SAMPLE_W+2:0] hi;
      logic signed [SAMPLE_W+2:0] lo;
      hi = (SAMPLE_W+3)'(signed'({1'b0, {(SAMPLE_W-1){1'b1}}}));
      lo = -hi - (SAMPLE_W+3)'(1);
      if (v > hi) begin
         return hi[SAMPLE_W-1:0];
      end else if (v < lo) begin
         return lo[SAMPLE_W-1:0];
      end
      return v[SAMPLE_W-1:0];
   endfunction

   // register read decode, used for the read path
   function automatic logic [DATA_W-1:0] readMux(
      input logic [ADDR_W-1:0] a,
      input qmc_t q,
      input mixer_t [MIXERS-1:0] m,
      input logic [1:0] ctl,
      input logic [2:0] pend
   );
      logic [DATA_W-1:0] r;
      r = '0;
      unique case (a)
         GAIN_C_OFFSET: r[GAIN_W-1:0] = q.gainC;
         GAIN_D_OFFSET: begin
            r[GAIN_W-1:0] = q.gainD;
            r[DELAY_AB_LSB+:2] = q.delayAB;
            r[DELAY_CD_LSB+:2] = q.delayCD;
         end
         // upper reserved bits read zero
         CD_PHASE_OFFSET: r[PHASE_W-1:0] = q.cd_pair_phase_correction;
         AB_SHIFT_OFFSET: r = m[MIX_AB].phaseShift;
         CD_SHIFT_OFFSET: r = m[MIX_CD].phaseShift;
         AB_FREQ_LO_OFFSET: r = m[MIX_AB].frequencyWord[DATA_W-1:0];
         AB_FREQ_HI_OFFSET: r = m[MIX_AB].frequencyWord[FREQ_W-1:DATA_W];
         CD_FREQ_LO_OFFSET: r = m[MIX_CD].frequencyWord[DATA_W-1:0];
         CD_FREQ_HI_OFFSET: r = m[MIX_CD].frequencyWord[FREQ_W-1:DATA_W];
         SYNC_CTRL_OFFSET: r[1:0] = ctl;
         SYNC_STAT_OFFSET: r[2:0] = pend;
         default: r = '0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // register bank: staged values, active values, auto-sync
   qmc_t qmcStage;
   qmc_t next_qmcStage;
   qmc_t next_qmcActive;
   mixer_t [MIXERS-1:0] mixStage;
   mixer_t [MIXERS-1:0] next_mixStage;
   mixer_t [MIXERS-1:0] next_mixActive;
   logic [1:0] syncCtrl;
   logic [1:0] next_syncCtrl;
   logic [2:0] pending;
   logic [2:0] next_pending;
   logic [DATA_W-1:0] next_rdata;
   logic qmcLoad;
   logic [MIXERS-1:0] mixLoad;
   logic [2:0] stageHit;

   always_comb begin
      next_qmcStage = qmcStage;
      next_mixStage = mixStage;
      next_qmcActive = qmcActive;
      next_mixActive = mixActive;
      next_syncCtrl = syncCtrl;
      qmcLoad = syncIn;
      mixLoad = {MIXERS{syncIn}};
      stageHit = 3'h0;
      if (wr) begin
         unique case (addr)
            GAIN_C_OFFSET: begin
               next_qmcStage.gainC = wdata[GAIN_W-1:0];
               stageHit[PEND_QMC_BIT] = 1'b1;
            end
            GAIN_D_OFFSET: begin
               next_qmcStage.gainD = wdata[GAIN_W-1:0];
               next_qmcStage.delayAB = wdata[DELAY_AB_LSB+:2];
               next_qmcStage.delayCD = wdata[DELAY_CD_LSB+:2];
               stageHit[PEND_QMC_BIT] = 1'b1;
            end
            CD_PHASE_OFFSET: begin
               next_qmcStage.cd_pair_phase_correction = wdata[PHASE_W-1:0];
               stageHit[PEND_QMC_BIT] = 1'b1;
               if (syncCtrl[QMC_SYNC_BIT]) begin
                  qmcLoad = 1'b1;
               end
            end
            AB_SHIFT_OFFSET: begin
               next_mixStage[MIX_AB].phaseShift = wdata;
               stageHit[PEND_AB_BIT] = 1'b1;
               if (syncCtrl[MIX_SYNC_BIT]) begin
                  mixLoad[MIX_AB] = 1'b1;
               end
            end
            CD_SHIFT_OFFSET: begin
               next_mixStage[MIX_CD].phaseShift = wdata;
               stageHit[PEND_CD_BIT] = 1'b1;
               if (syncCtrl[MIX_SYNC_BIT]) begin
                  mixLoad[MIX_CD] = 1'b1;
               end
            end
            AB_FREQ_LO_OFFSET: begin
               next_mixStage[MIX_AB].frequencyWord[DATA_W-1:0] = wdata;
               stageHit[PEND_AB_BIT] = 1'b1;
            end
            AB_FREQ_HI_OFFSET: begin
               next_mixStage[MIX_AB].frequencyWord[FREQ_W-1:DATA_W] = wdata;
               stageHit[PEND_AB_BIT] = 1'b1;
            end
            CD_FREQ_LO_OFFSET: begin
               next_mixStage[MIX_CD].frequencyWord[DATA_W-1:0] = wdata;
               stageHit[PEND_CD_BIT] = 1'b1;
            end
            CD_FREQ_HI_OFFSET: begin
               next_mixStage[MIX_CD].frequencyWord[FREQ_W-1:DATA_W] = wdata;
               stageHit[PEND_CD_BIT] = 1'b1;
            end
            SYNC_CTRL_OFFSET: next_syncCtrl = wdata[1:0];
            default: begin
            end
         endcase
      end
      // the load takes the value written in the same cycle, so the final write counts
      if (qmcLoad) begin
         next_qmcActive = next_qmcStage;
      end
      for (int i = 0; i < MIXERS; i++) begin
         if (mixLoad[i]) begin
            next_mixActive[i] = next_mixStage[i];
         end
      end
      // pending shows staged data not yet active; a clear by load is overridden by no write
      next_pending = pending;
      if (qmcLoad) begin
         next_pending[PEND_QMC_BIT] = 1'b0;
      end else if (stageHit[PEND_QMC_BIT]) begin
         next_pending[PEND_QMC_BIT] = 1'b1;
      end
      if (mixLoad[MIX_AB]) begin
         next_pending[PEND_AB_BIT] = 1'b0;
      end else if (stageHit[PEND_AB_BIT]) begin
         next_pending[PEND_AB_BIT] = 1'b1;
      end
      if (mixLoad[MIX_CD]) begin
         next_pending[PEND_CD_BIT] = 1'b0;
      end else if (stageHit[PEND_CD_BIT]) begin
         next_pending[PEND_CD_BIT] = 1'b1;
      end
      next_rdata = rd ? readMux(addr, qmcStage, mixStage, syncCtrl, pending) : '0;
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         qmcStage <= QMC_RESET;
         qmcActive <= QMC_RESET;
         mixStage <= {MIXERS{MIXER_RESET}};
         mixActive <= {MIXERS{MIXER_RESET}};
         syncCtrl <= SYNC_CTRL_RESET;
         pending <= 3'h0;
         rdata <= '0;
      end else if (ce) begin
         qmcStage <= next_qmcStage;
         qmcActive <= next_qmcActive;
         mixStage <= next_mixStage;
         mixActive <= next_mixActive;
         syncCtrl <= next_syncCtrl;
         pending <= next_pending;
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // CD quadrature correction datapath
   logic signed [SAMPLE_W+2:0] gainedC;
   logic signed [SAMPLE_W+2:0] gainedD;
   logic signed [SAMPLE_W+2:0] crossTerm;
   logic signed [SAMPLE_W+2:0] sumC;
   logic signed [SAMPLE_W-1:0] next_correctedC;
   logic signed [SAMPLE_W-1:0] next_correctedD;
   logic signed [SAMPLE_W+GAIN_W:0] prodC;
   logic signed [SAMPLE_W+GAIN_W:0] prodD;
   logic signed [SAMPLE_W+PHASE_W-1:0] prodX;

   always_comb begin
      // gain is unsigned with the binary point above bit 9
      prodC = sampleC * $signed({1'b0, qmcActive.gainC});
      prodD = sampleD * $signed({1'b0, qmcActive.gainD});
      gainedC = (SAMPLE_W+3)'(prodC >>> GAIN_FRAC);
      gainedD = (SAMPLE_W+3)'(prodD >>> GAIN_FRAC);
      prodX = sampleD * $signed(qmcActive.cd_pair_phase_correction);
      crossTerm = (SAMPLE_W+3)'(prodX >>> PHASE_FRAC);
      sumC = gainedC + crossTerm;
      // saturate rather than wrap so large corrections clip instead of folding over
      next_correctedC = sat16(sumC);
      next_correctedD = sat16(gainedD);
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         correctedC <= '0;
         correctedD <= '0;
      end else if (ce) begin
         correctedC <= next_correctedC;
         correctedD <= next_correctedD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // fine mixer phase accumulators and lookup address
   logic [FREQ_W-1:0] acc [MIXERS];
   logic [FREQ_W-1:0] next_acc [MIXERS];
   logic [SHIFT_W-1:0] lookup [MIXERS];
   logic [SHIFT_W-1:0] next_lookup [MIXERS];

   generate
      for (genvar g = 0; g < MIXERS; g++) begin : gen_mixer
         always_comb begin
            // wraps modulo 2^32, so one step is Fs/2^32 and negative words run backwards
            next_acc[g] = acc[g] + mixActive[g].frequencyWord;
            next_lookup[g] = acc[g][FREQ_W-1:FREQ_W-SHIFT_W] + mixActive[g].phaseShift;
         end

         always_ff @(posedge clock or negedge rstN) begin
            if (!rstN) begin
               acc[g] <= FREQ_RESET;
               lookup[g] <= SHIFT_RESET;
            end else if (ce) begin
               acc[g] <= next_acc[g];
               lookup[g] <= next_lookup[g];
            end
         end
      end
   endgenerate

   assign abLookupAddr = lookup[MIX_AB];
   assign cdLookupAddr = lookup[MIX_CD];

endmodule
`default_nettype wire

// [test/qmc_nco_phase_shadow_load_monitor.sv]
// checker: auto-sync loads, staging holds and read data timing of the phase shadow bank
`timescale 1ns/1ps
`default_nettype none
module qmc_nco_phase_shadow_load_monitor
   import qmc_nco_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic syncIn,
   input wire qmc_t qmcActive,
   input wire mixer_t [MIXERS-1:0] mixActive
);
   logic [1:0] ctl;
   logic [1:0] next_ctl;
   logic qW, abW, cdW;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////////
   // enable copy: a final write loads only while its auto-sync enable is set
   assign qW = ce && wr && addr == CD_PHASE_OFFSET && ctl[QMC_SYNC_BIT];
   assign abW = ce && wr && addr == AB_SHIFT_OFFSET && ctl[MIX_SYNC_BIT];
   assign cdW = ce && wr && addr == CD_SHIFT_OFFSET && ctl[MIX_SYNC_BIT];
   always_comb begin
      next_ctl = ctl;
      if (ce && wr && addr == SYNC_CTRL_OFFSET) begin
         next_ctl = wdata[1:0];
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctl <= SYNC_CTRL_RESET;
      end else begin
         ctl <= next_ctl;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence abHiThenShift;
      ce && wr && addr == AB_FREQ_HI_OFFSET && !syncIn ##1 !wr ##1 abW;
   endsequence
   ab_pair_load_a: assert property (abHiThenShift |=>
      mixActive[MIX_AB].frequencyWord[31:16] == $past(wdata, 3)
      && mixActive[MIX_AB].phaseShift == $past(wdata)) else $error("AB group not loaded");
   qmc_load_a: assert property (qW |=>
      qmcActive.cd_pair_phase_correction == $past(wdata[11:0])) else $error("phase not loaded");
   qmc_hold_a: assert property (!syncIn && !qW |=> $stable(qmcActive))
      else $error("active correction changed without sync");
   ab_hold_a: assert property (!syncIn && !abW |=> $stable(mixActive[MIX_AB]))
      else $error("active AB mixer changed without sync");
   cd_load_a: assert property (cdW |=> mixActive[MIX_CD].phaseShift == $past(wdata))
      else $error("CD shift not loaded");
   cd_hold_a: assert property (!syncIn && !cdW |=> $stable(mixActive[MIX_CD]))
      else $error("active CD mixer changed without sync");
   read_idle_a: assert property (ce && !rd |=> rdata == '0) else $error("read data not idle");
   ctl_read_a: assert property (ce && rd && addr == SYNC_CTRL_OFFSET |=>
      rdata == {14'h0, $past(ctl)}) else $error("sync enables read wrong");
endmodule
bind qmc_nco_phase_shadow_load qmc_nco_phase_shadow_load_monitor i_monitor (.clock(clock),
   .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .syncIn(syncIn), .qmcActive(qmcActive), .mixActive(mixActive));
`default_nettype wire

// [test/qmc_nco_phase_shadow_load_bench.sv]
// bench: reset values, staging, auto-sync and external sync loads, C-path correction
`timescale 1ns/1ps
`default_nettype none
module qmc_nco_phase_shadow_load_bench
   import qmc_nco_pkg::*;
   ;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic syncIn = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic [DATA_W-1:0] rdata, d, s, gd;
   logic signed [SAMPLE_W-1:0] sampleC = '0;
   logic signed [SAMPLE_W-1:0] sampleD = '0;
   logic signed [SAMPLE_W-1:0] correctedC, correctedD;
   logic [SHIFT_W-1:0] abLookupAddr, cdLookupAddr;
   qmc_t qmcActive, qExp;
   mixer_t [MIXERS-1:0] mixActive;
   mixer_t mExp;
   logic [31:0] seed = 32'h0000_9D00;
   logic [31:0] f;
   logic [11:0] p;
   logic [1:0] ctl;
   int k;
   int miscompares = 0;
   int tests_run = 0;
   localparam logic [7:0] RA [9] = '{8'h0E, 8'h0F, 8'h11, 8'h12, 8'h13, 8'h14, 8'h1E, 8'h1F, 8'h20};
   localparam logic [15:0] RV [9] = '{16'h0400, 16'h0400, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3,
      16'h0, 16'h0};

   qmc_nco_phase_shadow_load i_qmc_nco_phase_shadow_load (.clock, .nrst, .ce, .addr, .wdata,
      .wr, .rd, .rdata, .syncIn, .sampleC, .sampleD, .correctedC, .correctedD, .abLookupAddr,
      .cdLookupAddr, .qmcActive, .mixActive);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   function automatic logic signed [15:0] sat16(int v);
      return (v > 32767) ? 16'h7FFF : (v < -32768) ? 16'h8000 : 16'(v);
   endfunction
   task automatic chk(string n, logic [95:0] e, logic [95:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic wreg(logic [7:0] a, logic [15:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(logic [7:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic sync_pulse();
      @(posedge clock);
      syncIn <= 1'b1;
      @(posedge clock);
      syncIn <= 1'b0;
      #1;
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clock = ~clock;
   end
   initial begin
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk("qmc reset", QMC_RESET, qmcActive);
      chk("mixer reset", {MIXER_RESET, MIXER_RESET}, mixActive);
      for (int i = 0; i < 9; i++) begin
         rreg(RA[i]);
         chk("reset read", RV[i], d);
      end
      // accumulators still at zero, so the lookup address is the shift alone
      for (int g = 0; g < 2; g++) begin
         s = rnd();
         wreg(AB_SHIFT_OFFSET + 8'(g), s);
         @(posedge clock);
         #1;
         chk("lookup", s, g ? cdLookupAddr : abLookupAddr);
      end
      for (int n = 0; n < 12; n++) begin
         ctl = n == 0 ? 2'h3 : n == 1 ? 2'h0 : 2'(rnd());
         wreg(SYNC_CTRL_OFFSET, {14'h0, ctl});
         for (int g = 0; g < 2; g++) begin
            f = {rnd(), rnd()};
            s = rnd();
            mExp = mixActive[g];
            wreg(AB_FREQ_LO_OFFSET + 8'(2 * g), f[15:0]);
            rreg(SYNC_STAT_OFFSET);
            chk("pending", 16'(2 << g), d);
            wreg(AB_FREQ_HI_OFFSET + 8'(2 * g), f[31:16]);
            chk("staged word", mExp, mixActive[g]);
            wreg(AB_SHIFT_OFFSET + 8'(g), s);
            if (!ctl[MIX_SYNC_BIT]) begin
               chk("no autosync", mExp, mixActive[g]);
               sync_pulse();
            end
            chk("mixer load", {f, s}, mixActive[g]);
            rreg(AB_FREQ_HI_OFFSET + 8'(2 * g));
            chk("word read", f[31:16], d);
         end
         qExp = qmcActive;
         gd = rnd() & 16'hF7FF;
         p = 12'(rnd());
         s = rnd();
         wreg(GAIN_C_OFFSET, {5'h0, s[10:0]});
         wreg(GAIN_D_OFFSET, gd);
         chk("qmc staged", qExp, qmcActive);
         wreg(CD_PHASE_OFFSET, {4'h0, p});
         if (!ctl[QMC_SYNC_BIT]) begin
            chk("qmc no autosync", qExp, qmcActive);
            sync_pulse();
         end
         chk("qmc load", {gd[15:12], s[10:0], gd[10:0], p}, qmcActive);
         rreg(CD_PHASE_OFFSET);
         chk("phase read", {4'h0, p}, d);
      end
      // unity gains keep the products exact; extreme phases and samples reach saturation
      wreg(SYNC_CTRL_OFFSET, 16'h0003);
      wreg(GAIN_C_OFFSET, 16'h0400);
      wreg(GAIN_D_OFFSET, 16'h0400);
      for (int n = 0; n < 12; n++) begin
         if (n % 4 == 0) begin
            p = n == 0 ? 12'h800 : n == 4 ? 12'h7FF : 12'(rnd());
            wreg(CD_PHASE_OFFSET, {4'h0, p});
         end
         k = (n % 4 < 2) ? 7 : int'($signed(4'(rnd())));
         s = (n % 4 == 0) ? 16'h7FFF : (n % 4 == 1) ? 16'h8000 : rnd();
         @(posedge clock);
         sampleC <= s;
         sampleD <= 16'(k * 4096);
         @(posedge clock);
         #1;
         chk("corrected C", sat16(int'($signed(s)) + k * int'($signed(p))), correctedC);
         chk("corrected D", 16'(k * 4096), correctedD);
      end
      // low word zero: the upper accumulator half steps by exactly the high word each cycle
      f = {rnd(), 16'h0000};
      wreg(AB_FREQ_LO_OFFSET, f[15:0]);
      wreg(AB_FREQ_HI_OFFSET, f[31:16]);
      wreg(AB_SHIFT_OFFSET, 16'h0000);
      @(posedge clock);
      #1 s = abLookupAddr;
      @(posedge clock);
      #1 chk("nco step", 16'(s + f[31:16]), abLookupAddr);
      // with the enable low a write must leave the active mixer untouched
      mExp = mixActive[MIX_AB];
      @(posedge clock);
      ce <= 1'b0;
      wreg(AB_SHIFT_OFFSET, ~mExp.phaseShift);
      @(posedge clock);
      ce <= 1'b1;
      #1;
      chk("ce freeze", mExp, mixActive[MIX_AB]);
      close_out();
   end
endmodule
`default_nettype wire
